// ==== shared/eco_defines.vh ====
// constants for the external clock output divider: field positions of the
// interface configuration word, reset values and rate encodings.
// assumes it is included by bare name from every design file that needs it.
`ifndef ECO_DEFINES_VH
`define ECO_DEFINES_VH

// configuration word layout
`define ECO_CFG_W            32
`define ECO_TIM_HI           18
`define ECO_TIM_LO           16
`define ECO_TIM_W            3
`define ECO_MODE_BIT         2
`define ECO_OFF_BIT          3

// timing ratio codes: full rate, half rate; the rest are treated as half
`define ECO_TIM_FULL         3'h0
`define ECO_TIM_HALF         3'h1

// reset values: half then half again gives the quarter rate, clock on
`define ECO_TIM_RST          3'h1
`define ECO_MODE_RST         1'h1
`define ECO_OFF_RST          1'h0

// reported rate of the output, as a divisor exponent of system_clock
`define ECO_RATE_FULL        2'h0
`define ECO_RATE_HALF        2'h1
`define ECO_RATE_QUARTER     2'h2
`define ECO_RATE_STOPPED     2'h3

// output pin levels
`define ECO_PIN_LOW          1'h0
`define ECO_PIN_HIGH         1'h1
`define ECO_OE_ON            1'h1

// divider depth and reset values of the remaining registers
`define ECO_STAGES           2
`define ECO_PHASE_RST        1'h0
`define ECO_PEND_RST         1'h0
`define ECO_RUN_RST          1'h1
`define ECO_RSV_RST          1'h0

`endif

// ==== hw/eco_half_stage.v ====
// one divider stage: passes every tick through, or every second tick.
// assumes tick_in comes from logic on the same clock; each cycle it is high is one tick, and it may stay high.
`timescale 1ns/100ps
`include "eco_defines.vh"

module eco_half_stage (
    input  wire clk_in,
    input  wire rst_in,
    input  wire clear_in,
    input  wire halve_in,
    input  wire tick_in,
    output wire tick_out
);

    reg  phase_q;
    wire phase_d;

    // phase flips on each incoming tick, cleared whenever a new setting is applied
    assign phase_d = clear_in ? `ECO_PHASE_RST : (tick_in ? ~phase_q : phase_q);

    always @(posedge clk_in) begin
        if (rst_in) begin
            phase_q <= `ECO_PHASE_RST;
        end else begin
            phase_q <= phase_d;
        end
    end

    // halving keeps only the ticks that land on the second phase
    assign tick_out = tick_in & (~halve_in | phase_q);

endmodule // eco_half_stage

// ==== hw/eco_clock_out.v ====
// external clock output divider: makes the external clock pin from the
// system clock at full, half or quarter rate, with a disable bit.
// assumes the configuration word and its write strobe come from register
// logic on clk_in; the pad turns ext_clock_out and its enable into the pin.
// the pin toggles on clk_in edges, so system_clock here is clk_in / 2.
// the pad enable stays on at all times, reset included.
`timescale 1ns/100ps
`include "eco_defines.vh"

// Function
// - pin runs at full, half or quarter
// - timing field and ratio bit pick rate
// - quarter rate after reset until reconfigured
// - disable bit set stops pin toggling
// - pin stays driven, never high-impedance
module eco_clock_out (
    input  wire                   clk_in,
    input  wire                   rst_in,
    input  wire                   cfg_write_in,
    input  wire [`ECO_CFG_W-1:0]  cfg_word_in,
    output wire                   ext_clock_out,
    output wire                   ext_clock_oe_out,
    output wire [1:0]             rate_code_out,
    output wire                   clock_running_out,
    output wire                   cfg_reserved_out
);

    // active configuration
    reg  [`ECO_TIM_W-1:0] tim_q;
    reg  [`ECO_TIM_W-1:0] tim_d;
    reg                   mode_q;
    reg                   mode_d;
    reg                   off_q;
    reg                   off_d;

    // a write waiting for the pin to reach low before it is applied;
    // only the last write before the apply counts
    reg  [`ECO_TIM_W-1:0] pend_tim_q;
    reg  [`ECO_TIM_W-1:0] pend_tim_d;
    reg                   pend_mode_q;
    reg                   pend_mode_d;
    reg                   pend_off_q;
    reg                   pend_off_d;
    reg                   pend_q;
    reg                   pend_d;

    // pin and status registers
    reg                   pin_q;
    reg                   pin_d;
    reg                   oe_q;
    reg  [1:0]            rate_q;
    reg  [1:0]            rate_d;
    reg                   run_q;
    reg                   run_d;
    reg                   rsv_q;
    reg                   rsv_d;

    // settings handshake and stage controls
    wire                  apply;
    wire                  stage1_halve;
    wire                  stage2_halve;
    wire                  tick2;
    wire                  base_tick;

    // halving request per stage and the tick chain between the stages:
    // entry 0 is the undivided tick, the last entry toggles the pin
    wire [`ECO_STAGES-1:0] stage_halve;
    wire [`ECO_STAGES:0]   tick_chain;

    // every clk_in edge is one system_clock half period
    assign base_tick = 1'h1;

    // a new setting takes effect only while the pin is low, so the external
    // logic never sees a runt high pulse when the ratio changes
    assign apply = pend_q & (pin_q == `ECO_PIN_LOW);

    // stage one: timing ratio selects full or half rate
    assign stage1_halve = (tim_q != `ECO_TIM_FULL);

    // stage two: ratio bit selects that rate or half of it
    assign stage2_halve = mode_q;

    // the first stage works on the raw tick, the second on its output
    assign stage_halve   = {stage2_halve, stage1_halve};
    assign tick_chain[0] = base_tick;
    assign tick2         = tick_chain[`ECO_STAGES];

    // cascade of halving stages; both phases restart together on a change,
    // so the first pin period after it is a whole one
    genvar g;
    generate
        for (g = 0; g < `ECO_STAGES; g = g + 1) begin : g_stage
            eco_half_stage u_stage (
                .clk_in   (clk_in),
                .rst_in   (rst_in),
                .clear_in (apply),
                .halve_in (stage_halve[g]),
                .tick_in  (tick_chain[g]),
                .tick_out (tick_chain[g+1])
            );
        end
    endgenerate

    // capture a software write; a later write replaces an unapplied one;
    // a write in the cycle of an apply is kept, never lost
    always @* begin
        pend_tim_d  = pend_tim_q;
        pend_mode_d = pend_mode_q;
        pend_off_d  = pend_off_q;
        pend_d      = pend_q;
        if (cfg_write_in) begin
            pend_tim_d  = cfg_word_in[`ECO_TIM_HI:`ECO_TIM_LO];
            pend_mode_d = cfg_word_in[`ECO_MODE_BIT];
            pend_off_d  = cfg_word_in[`ECO_OFF_BIT];
            pend_d      = 1'h1;
        end else if (apply) begin
            pend_d      = 1'h0;
        end
    end

    // move the waiting write into the active settings;
    // the stage phases restart in the same cycle
    always @* begin
        tim_d  = tim_q;
        mode_d = mode_q;
        off_d  = off_q;
        if (apply) begin
            tim_d  = pend_tim_q;
            mode_d = pend_mode_q;
            off_d  = pend_off_q;
        end
    end

    // pin toggles on each divided tick; when disabled it only falls;
    // an apply holds the pin low one cycle while the stages restart
    always @* begin
        pin_d = pin_q;
        if (off_q) begin
            pin_d = `ECO_PIN_LOW;
        end else if (apply) begin
            pin_d = `ECO_PIN_LOW;
        end else if (tick2) begin
            pin_d = ~pin_q;
        end
    end

    // status: rate now produced on the pin, stopped while disabled
    always @* begin
        if (off_q) begin
            rate_d = `ECO_RATE_STOPPED;
        end else begin
            case ({stage1_halve, stage2_halve})
                2'h0:    rate_d = `ECO_RATE_FULL;
                2'h1:    rate_d = `ECO_RATE_HALF;
                2'h2:    rate_d = `ECO_RATE_HALF;
                2'h3:    rate_d = `ECO_RATE_QUARTER;
                default: rate_d = `ECO_RATE_STOPPED;
            endcase
        end
    end

    // status: whether the pin toggles at all
    always @* begin
        run_d = ~off_q;
    end

    // status: the timing field holds a code with no rate of its own; such
    // codes act as the half code, the flag lets software spot the mistake
    always @* begin
        rsv_d = (tim_q != `ECO_TIM_FULL) && (tim_q != `ECO_TIM_HALF);
    end

    // configuration registers, reset to the quarter rate with clock on;
    // no write is pending after reset, so the quarter rate stands until one
    always @(posedge clk_in) begin
        if (rst_in) begin
            tim_q       <= `ECO_TIM_RST;
            mode_q      <= `ECO_MODE_RST;
            off_q       <= `ECO_OFF_RST;
            pend_tim_q  <= `ECO_TIM_RST;
            pend_mode_q <= `ECO_MODE_RST;
            pend_off_q  <= `ECO_OFF_RST;
            pend_q      <= `ECO_PEND_RST;
        end else begin
            tim_q       <= tim_d;
            mode_q      <= mode_d;
            off_q       <= off_d;
            pend_tim_q  <= pend_tim_d;
            pend_mode_q <= pend_mode_d;
            pend_off_q  <= pend_off_d;
            pend_q      <= pend_d;
        end
    end

    // pin and status registers; the enable stays on even in reset,
    // so the board never sees a floating clock line
    always @(posedge clk_in) begin
        if (rst_in) begin
            pin_q  <= `ECO_PIN_LOW;
            oe_q   <= `ECO_OE_ON;
            rate_q <= `ECO_RATE_QUARTER;
            run_q  <= `ECO_RUN_RST;
            rsv_q  <= `ECO_RSV_RST;
        end else begin
            pin_q  <= pin_d;
            oe_q   <= `ECO_OE_ON;
            rate_q <= rate_d;
            run_q  <= run_d;
            rsv_q  <= rsv_d;
        end
    end

    // every output comes straight from its register
    assign ext_clock_out     = pin_q;
    assign ext_clock_oe_out  = oe_q;
    assign rate_code_out     = rate_q;
    assign clock_running_out = run_q;
    assign cfg_reserved_out  = rsv_q;

endmodule // eco_clock_out

// ==== bench/eco_clock_out_assertions.sv ====
// checker for the external clock output divider, on the top ports only.
// assumes a bind into eco_clock_out; rst_in synchronous, active high.
`timescale 1ns/100ps
module eco_clock_out_checker (
    input wire        clk_in,
    input wire        rst_in,
    input wire        cfg_write_in,
    input wire [31:0] cfg_word_in,
    input wire        ext_clock_out,
    input wire        ext_clock_oe_out,
    input wire [1:0]  rate_code_out,
    input wire        clock_running_out,
    input wire        cfg_reserved_out
);
    reg  [31:0] word_q;
    reg         started_q = 1'h0;
    wire [1:0]  want_w = word_q[3] ? 2'h3 : {1'b0, |word_q[18:16]} + {1'b0, word_q[2]};
    // last written word, reference for the status outputs
    always @(posedge clk_in) begin
        if (rst_in) word_q <= 32'h00010004;
        else if (cfg_write_in) word_q <= cfg_word_in;
    end
    // marks the first edge, before which no register of the design holds a value
    always @(posedge clk_in) begin
        started_q <= 1'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // pad enable is checked through reset as well, from the second edge on
    property p_drive; disable iff (1'h0) started_q |-> ext_clock_oe_out; endproperty
    a_drive: assert property (p_drive) else $error("pin not driven");
    property p_boot;
        $fell(rst_in) |-> rate_code_out == 2'h2 ##0 !ext_clock_out [*4] ##1 ext_clock_out;
    endproperty
    a_boot: assert property (p_boot) else $error("bad start");
    property p_rate; cfg_write_in |-> ##[2:8] rate_code_out == want_w; endproperty
    a_rate: assert property (p_rate) else $error("bad rate");
    property p_resv;
        cfg_write_in |-> ##[2:8] cfg_reserved_out == (word_q[18:16] > 3'h1);
    endproperty
    a_resv: assert property (p_resv) else $error("bad reserved");
    property p_run; cfg_write_in |-> ##[2:8] clock_running_out == !word_q[3]; endproperty
    a_run: assert property (p_run) else $error("bad running");
    property p_stop; rate_code_out == 2'h3 |-> !ext_clock_out && !clock_running_out; endproperty
    a_stop: assert property (p_stop) else $error("pin not stopped");
endmodule // eco_clock_out_checker
bind eco_clock_out eco_clock_out_checker chk (.clk_in(clk_in), .rst_in(rst_in),
    .cfg_write_in(cfg_write_in), .cfg_word_in(cfg_word_in), .ext_clock_out(ext_clock_out),
    .ext_clock_oe_out(ext_clock_oe_out), .rate_code_out(rate_code_out),
    .clock_running_out(clock_running_out), .cfg_reserved_out(cfg_reserved_out));

// ==== bench/eco_board_model.sv ====
// board logic fed by the clock pin: last level length, rising edge count.
// assumes pin_in is sampled on clk_in.
`timescale 1ns/100ps
module eco_board_model (
    input  wire       clk_in,
    input  wire       pin_in,
    output reg  [3:0] phase_out = 4'h0,
    output reg  [7:0] rises_out = 8'h00
);
    reg       last_q = 1'b0;
    reg [3:0] run_q = 4'h0;
    // length of each pin level in clk_in cycles
    always @(posedge clk_in) begin
        last_q <= pin_in;
        if (pin_in != last_q) begin
            phase_out <= run_q;
            run_q <= 4'h1;
        end else if (run_q != 4'hF) begin
            run_q <= run_q + 4'h1;
        end
    end
    // board flops clocked by the pin
    always @(posedge pin_in) begin
        rises_out <= rises_out + 8'h01;
    end
endmodule // eco_board_model

// ==== bench/eco_clock_out_bench.sv ====
// bench for the external clock output divider: random and corner writes.
// assumes design, checker and board model are compiled first.
`timescale 1ns/100ps
module eco_clock_out_bench;
    reg        clk_in = 1'b0;
    reg        rst_in = 1'b1;
    reg        cfg_write_in = 1'b0;
    reg [31:0] cfg_word_in = 32'h0, seed = 32'h8, w;
    reg [7:0]  r0;
    integer    n_mismatch = 0, samples_checked = 0, i;
    wire       pin, oe, running, resv;
    wire [1:0] rate;
    wire [3:0] phase;
    wire [7:0] rises;
    always #50 clk_in = ~clk_in;
    eco_clock_out dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_write_in(cfg_write_in),
        .cfg_word_in(cfg_word_in), .ext_clock_out(pin), .ext_clock_oe_out(oe),
        .rate_code_out(rate), .clock_running_out(running), .cfg_reserved_out(resv));
    eco_board_model board (.clk_in(clk_in), .pin_in(pin), .phase_out(phase), .rises_out(rises));
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [1:0] want(input [31:0] v);
        want = v[3] ? 2'h3 : {1'b0, |v[18:16]} + {1'b0, v[2]};
    endfunction
    task check(input [63:0] name, input [7:0] seen, input [7:0] exp); begin
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %0h seen %0h", name, exp, seen);
        end
    end endtask
    task cycles(input integer n); begin
        repeat (n) @(posedge clk_in);
        #1;
    end endtask
    task tally_and_finish; begin
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    end endtask
    // one write, then status and measured pin rate
    task apply(input [31:0] v); begin
        cfg_word_in = v;
        cfg_write_in = 1'b1;
        cycles(1);
        cfg_write_in = 1'b0;
        cycles(24);
        check("rate", {6'h00, rate}, {6'h00, want(v)});
        check("running", {7'h00, running}, {7'h00, !v[3]});
        check("reserved", {7'h00, resv}, {7'h00, v[18:16] > 3'h1});
        r0 = rises;
        cycles(16);
        if (v[3]) check("rises", rises, r0);
        else check("phase", {4'h0, phase}, 8'h01 << want(v));
    end endtask
    // boot, corner and random writes, overwrite, mid-run reset
    initial begin
        cycles(6);
        check("oe", {7'h00, oe}, 8'h01);
        rst_in = 1'b0;
        cycles(20);
        check("phase", {4'h0, phase}, 8'h04);
        for (i = 0; i < 14; i = i + 1) begin
            seed = xs(seed);
            w = seed;
            if (i < 4) w[18:16] = {2'h0, i[1]};
            if (i < 4) w[2] = i[0];
            w[3] = (i % 5 == 4);
            apply(w);
        end
        cfg_word_in = 32'h00000008;
        cfg_write_in = 1'b1;
        cycles(1);
        apply(32'h00000000);
        rst_in = 1'b1;
        cycles(3);
        check("oe", {7'h00, oe}, 8'h01);
        cycles(3);
        rst_in = 1'b0;
        cycles(20);
        check("phase", {4'h0, phase}, 8'h04);
        tally_and_finish;
    end
    // watchdog well past the expected run
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
endmodule // eco_clock_out_bench
